// ===== rtl/dtp_pkg.sv
// Constants shared by the dual timer/counter and PWM block
package dtp_pkg;
  // Bus geometry
  localparam int          DTP_ADDR_W      = 12;
  localparam int          DTP_DATA_W      = 32;
  // Register indices; byte address is four times the index
  localparam logic [7:0]  DTP_IDX_CTRL    = 8'h88;
  localparam logic [7:0]  DTP_IDX_MODE    = 8'h89;
  localparam logic [7:0]  DTP_IDX_A_LO    = 8'h8a;
  localparam logic [7:0]  DTP_IDX_B_LO    = 8'h8b;
  localparam logic [7:0]  DTP_IDX_A_HI    = 8'h8c;
  localparam logic [7:0]  DTP_IDX_B_HI    = 8'h8d;
  localparam logic [7:0]  DTP_IDX_PWMPSC  = 8'h91;
  localparam logic [7:0]  DTP_IDX_A_RL    = 8'h92;
  localparam logic [7:0]  DTP_IDX_B_RL    = 8'h93;
  localparam logic [7:0]  DTP_IDX_A_RH    = 8'h94;
  localparam logic [7:0]  DTP_IDX_B_RH    = 8'h95;
  // Reset values
  localparam logic [7:0]  DTP_RST_CTRL    = 8'h00;
  localparam logic [7:0]  DTP_RST_MODE    = 8'h00;
  localparam logic [7:0]  DTP_RST_PWMPSC  = 8'h24;
  localparam logic [7:0]  DTP_RST_BYTE    = 8'h00;
  // timer_control bits
  localparam int          DTP_B_OVF       = 7;
  localparam int          DTP_B_RUN       = 6;
  localparam int          DTP_A_OVF       = 5;
  localparam int          DTP_A_RUN       = 4;
  localparam int          DTP_XB_FLAG     = 3;
  localparam int          DTP_XB_TYPE     = 2;
  localparam int          DTP_XA_FLAG     = 1;
  localparam int          DTP_XA_TYPE     = 0;
  // timer_mode_select nibble layout, timer A low nibble, timer B high nibble
  localparam int          DTP_MODE_NIB    = 4;
  localparam int          DTP_MODE_LSB    = 0;
  localparam int          DTP_CT_BIT      = 2;
  localparam int          DTP_GATE_BIT    = 3;
  // timer_pwm_prescale_control layout
  localparam int          DTP_PSC_W       = 3;
  localparam int          DTP_A_PSC_LSB   = 0;
  localparam int          DTP_B_PSC_LSB   = 3;
  localparam int          DTP_A_PWM_EN    = 6;
  localparam int          DTP_B_PWM_EN    = 7;
  // Counting constants
  localparam logic [7:0]  DTP_BYTE_ONE    = 8'h01;
  localparam logic [7:0]  DTP_BYTE_MAX    = 8'hff;
  localparam logic [7:0]  DTP_BYTE_ZERO   = 8'h00;
  localparam logic [2:0]  DTP_PSC_TOP     = 3'h7;
  // Operating modes
  localparam logic [1:0]  DTP_MODE_VAR    = 2'h0;
  localparam logic [1:0]  DTP_MODE_AR16   = 2'h1;
  localparam logic [1:0]  DTP_MODE_AR8    = 2'h2;
  localparam logic [1:0]  DTP_MODE_SPLIT  = 2'h3;
endpackage : dtp_pkg

// ===== rtl/dtp_sync.sv
// Two-stage pin synchroniser with falling-edge detect
`timescale 1ns/1ps
module dtp_sync #(
  parameter int W = 4
) (
  // Clock and reset
  input  wire logic         sys_clk,
  input  wire logic         rst_n,
  // Pins and results
  input  wire logic [W-1:0] pin_async,
  output logic      [W-1:0] pin_level,
  output logic      [W-1:0] pin_fall
);
  import dtp_pkg::*;

  typedef struct packed {
    logic [W-1:0] stage1;
    logic [W-1:0] stage2;
    logic [W-1:0] prev;
  } dtp_sync_t;

  dtp_sync_t st;
  dtp_sync_t next_st;

  always_comb begin
    next_st        = st;
    next_st.stage1 = pin_async;
    next_st.stage2 = st.stage1;
    next_st.prev   = st.stage2;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '1;
    end else begin
      st <= next_st;
    end
  end

  assign pin_level = st.stage2;
  // High sample followed by low sample
  assign pin_fall  = st.prev & ~st.stage2;
endmodule : dtp_sync

// ===== rtl/dtp_pwm.sv
// Asymmetrical 8-bit PWM comparator with wrap-synchronised compare latch
`timescale 1ns/1ps
module dtp_pwm (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  // Control and count
  input  wire logic       pwm_en,
  input  wire logic [7:0] count,
  input  wire logic [7:0] cmp_wr,
  input  wire logic       wrap,
  // Waveform
  output logic            pwm_out
);
  import dtp_pkg::*;

  typedef struct packed {
    logic [7:0] cmp;
    logic       out;
  } dtp_pwm_t;

  dtp_pwm_t st;
  dtp_pwm_t next_st;

  always_comb begin
    next_st = st;
    if (wrap || !pwm_en) begin
      next_st.cmp = cmp_wr; // R18 R25
    end
    if (!pwm_en) begin
      next_st.out = 1'b0;
    end else if (st.cmp == DTP_BYTE_ZERO) begin
      next_st.out = 1'b0; // R19
    end else if (count == st.cmp) begin
      next_st.out = 1'b0; // R17
    end else if (count == DTP_BYTE_ZERO) begin
      next_st.out = 1'b1; // R17
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign pwm_out = st.out;
endmodule : dtp_pwm

// ===== rtl/dtp_top.sv
// Dual timer/counter with PWM, APB register slave
//
// Local design decision: the APB slave port.
`timescale 1ns/1ps
// Function
// R1: Mode 2 low byte reloads from high byte
// R2: Timer B in split mode holds count
// R3: Split mode: A low byte uses A controls
// R4: Split mode: A high byte times, uses B
// R5: Timer B still runs for baud when split
// R6: Overflow flags set by hardware, ack clears
// R7: Software sets run bits to start timers
// R8: Edge type: falling edge sets external flag
// R9: Level type: flag follows inverted pin
// R10: Type bit one edge, zero level
// R11: Gate bit requires interrupt pin high
// R12: Select bit picks clock or pin events
// R13: Mode bits pick four operating modes
// R14: Prescaler width is field plus one
// R15: PWM enable drives waveform onto pin
// R16: Software keeps counter select zero for PWM
// R17: PWM high at zero, low at compare
// R18: Compare write applies at high wrap
// R19: Compare zero keeps output low
// R20: PWM in mode 0 or 1 prescalers
// R21: Mode 1 reloads sixteen bits on wrap
// R22: Pin falling edge counts next cycle
// R23: Timer mode counts every clock
// R24: Mode 0 rollover sets flag
// R25: PWM off: port drives pin, latch follows
module dtp_top #(
  parameter int AW = dtp_pkg::DTP_ADDR_W
) (
  // Clock and reset
  input  wire logic                          sys_clk,
  input  wire logic                          rst_n,
  // APB slave
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [AW-1:0]                 paddr,
  input  wire logic [dtp_pkg::DTP_DATA_W-1:0] pwdata,
  output logic                               pready,
  output logic      [dtp_pkg::DTP_DATA_W-1:0] prdata,
  output logic                               pslverr,
  // Interrupt acknowledge from the core, one-cycle pulses
  input  wire logic                          tmr_a_ack,
  input  wire logic                          tmr_b_ack,
  input  wire logic                          ext_irq_a_ack,
  input  wire logic                          ext_irq_b_ack,
  // Flags toward the interrupt controller
  output logic                               tmr_a_overflow_flag,
  output logic                               tmr_b_overflow_flag,
  output logic                               ext_irq_a_flag,
  output logic                               ext_irq_b_flag,
  output logic                               tmr_b_baud_tick,
  // Pins
  input  wire logic                          tmr_a_pin_in,
  input  wire logic                          tmr_b_pin_in,
  input  wire logic                          ext_irq_a_pin,
  input  wire logic                          ext_irq_b_pin,
  output logic                               tmr_a_pin_out,
  output logic                               tmr_a_pin_oe_n,
  output logic                               tmr_b_pin_out,
  output logic                               tmr_b_pin_oe_n
);
  import dtp_pkg::*;

  typedef struct packed {
    logic [1:0][7:0]        lo;
    logic [1:0][7:0]        hi;
    logic [1:0][7:0]        rl;
    logic [1:0][7:0]        rh;
    logic [7:0]             ctrl;
    logic [7:0]             mode;
    logic [7:0]             pwmpsc;
    logic                   pready;
    logic                   pslverr;
    logic [DTP_DATA_W-1:0]  prdata;
    logic [1:0]             oe_n;
    logic                   baud;
  } dtp_state_t;

  dtp_state_t st;
  dtp_state_t next_st;
  logic [1:0] rst_pipe;
  logic       rst_sync_n;
  logic [3:0] pin_level;
  logic [3:0] pin_fall;
  logic [1:0] hi_wrap;
  logic [1:0] pwm_wave;

  // Register address match
  function automatic logic dtp_hit(input logic [AW-1:0] a, input logic [7:0] idx);
    return a == {{(AW-10){1'b0}}, idx, 2'b00};
  endfunction : dtp_hit

  // Reset release through two flops
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_pipe <= 2'h0;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end
  assign rst_sync_n = rst_pipe[1];

  // Pins: 0 timer A, 1 timer B, 2 ext A, 3 ext B
  dtp_sync #(
    .W(4)
  ) u_sync (
    .sys_clk  (sys_clk),
    .rst_n    (rst_sync_n),
    .pin_async({ext_irq_b_pin, ext_irq_a_pin, tmr_b_pin_in, tmr_a_pin_in}),
    .pin_level(pin_level),
    .pin_fall (pin_fall)
  );

  always_comb begin
    logic [1:0]      md;
    logic [1:0]      ovf;
    logic [1:0]      cnt_en;
    logic [7:0]      mask;
    logic [2:0]      psc;
    logic            pwm_on;
    logic            a_split;
    logic            split_hi_ovf;
    logic            wr;
    logic            acc;
    logic            hit;
    logic [7:0]      rd;
    logic [1:0][7:0] wr_lo;
    logic [1:0][7:0] wr_hi;
    logic [1:0]      lo_wr;
    logic [1:0]      hi_wr;
    md           = DTP_MODE_VAR;
    ovf          = 2'h0;
    cnt_en       = 2'h0;
    mask         = DTP_BYTE_ZERO;
    psc          = 3'h0;
    pwm_on       = 1'b0;
    split_hi_ovf = 1'b0;
    hi_wrap      = 2'h0;
    rd           = DTP_BYTE_ZERO;
    wr_lo        = '0;
    wr_hi        = '0;
    lo_wr        = 2'h0;
    hi_wr        = 2'h0;
    next_st      = st;
    a_split      = st.mode[DTP_MODE_LSB +: 2] == DTP_MODE_SPLIT;

    // Counting for both timers
    for (int i = 0; i < 2; i++) begin
      md     = st.mode[i*DTP_MODE_NIB + DTP_MODE_LSB +: 2]; // R13
      psc    = st.pwmpsc[(i == 0 ? DTP_A_PSC_LSB : DTP_B_PSC_LSB) +: DTP_PSC_W];
      pwm_on = st.pwmpsc[i == 0 ? DTP_A_PWM_EN : DTP_B_PWM_EN];
      // Run, gate and event selection
      cnt_en[i] = st.ctrl[i == 0 ? DTP_A_RUN : DTP_B_RUN] // R7 R3
                  && (!st.mode[i*DTP_MODE_NIB + DTP_GATE_BIT] || pin_level[i+2]) // R11
                  && (st.mode[i*DTP_MODE_NIB + DTP_CT_BIT] ? pin_fall[i] : 1'b1); // R12 R22 R23
      if (i == 1 && md == DTP_MODE_SPLIT) begin
        cnt_en[i] = 1'b0; // R2
      end
      mask = 8'(DTP_BYTE_MAX >> (DTP_PSC_TOP - psc)); // R14
      if (cnt_en[i]) begin
        case (md)
          DTP_MODE_VAR: begin
            next_st.lo[i] = 8'((st.lo[i] + DTP_BYTE_ONE) & mask);
            if ((st.lo[i] & mask) == mask) begin
              next_st.hi[i] = 8'(st.hi[i] + DTP_BYTE_ONE);
              if (st.hi[i] == DTP_BYTE_MAX) begin
                ovf[i]     = 1'b1; // R24
                hi_wrap[i] = 1'b1; // R20
              end
            end
          end
          DTP_MODE_AR16: begin
            if (pwm_on) begin
              // Linear prescaler, high byte free-running
              if (st.lo[i] == DTP_BYTE_MAX) begin
                next_st.lo[i] = st.rl[i]; // R20
                next_st.hi[i] = 8'(st.hi[i] + DTP_BYTE_ONE);
                if (st.hi[i] == DTP_BYTE_MAX) begin
                  ovf[i]     = 1'b1;
                  hi_wrap[i] = 1'b1;
                end
              end else begin
                next_st.lo[i] = 8'(st.lo[i] + DTP_BYTE_ONE);
              end
            end else if ({st.hi[i], st.lo[i]} == {DTP_BYTE_MAX, DTP_BYTE_MAX}) begin
              next_st.lo[i] = st.rl[i]; // R21
              next_st.hi[i] = st.rh[i]; // R21
              ovf[i]        = 1'b1; // R21
            end else begin
              {next_st.hi[i], next_st.lo[i]} = 16'({st.hi[i], st.lo[i]} + 16'h0001);
            end
          end
          DTP_MODE_AR8: begin
            if (st.lo[i] == DTP_BYTE_MAX) begin
              next_st.lo[i] = st.hi[i]; // R1
              ovf[i]        = 1'b1; // R1
            end else begin
              next_st.lo[i] = 8'(st.lo[i] + DTP_BYTE_ONE);
            end
          end
          DTP_MODE_SPLIT: begin
            next_st.lo[i] = 8'(st.lo[i] + DTP_BYTE_ONE); // R3
            ovf[i]        = st.lo[i] == DTP_BYTE_MAX; // R3
          end
          default: begin
            next_st.lo[i] = st.lo[i];
          end
        endcase
      end
    end

    // Split mode: timer A high byte counts clocks under timer B run
    if (a_split && st.ctrl[DTP_B_RUN]) begin
      next_st.hi[0] = 8'(st.hi[0] + DTP_BYTE_ONE); // R4
      split_hi_ovf  = st.hi[0] == DTP_BYTE_MAX; // R4
    end

    // APB access
    acc = psel && penable && !st.pready;
    wr  = psel && penable && st.pready && pwrite;
    hit = 1'b1;
    if (dtp_hit(paddr, DTP_IDX_CTRL)) begin
      rd = st.ctrl;
    end else if (dtp_hit(paddr, DTP_IDX_MODE)) begin
      rd = st.mode;
    end else if (dtp_hit(paddr, DTP_IDX_A_LO)) begin
      rd = st.lo[0];
    end else if (dtp_hit(paddr, DTP_IDX_B_LO)) begin
      rd = st.lo[1];
    end else if (dtp_hit(paddr, DTP_IDX_A_HI)) begin
      rd = st.hi[0];
    end else if (dtp_hit(paddr, DTP_IDX_B_HI)) begin
      rd = st.hi[1];
    end else if (dtp_hit(paddr, DTP_IDX_PWMPSC)) begin
      rd = st.pwmpsc;
    end else if (dtp_hit(paddr, DTP_IDX_A_RL)) begin
      rd = st.rl[0];
    end else if (dtp_hit(paddr, DTP_IDX_B_RL)) begin
      rd = st.rl[1];
    end else if (dtp_hit(paddr, DTP_IDX_A_RH)) begin
      rd = st.rh[0];
    end else if (dtp_hit(paddr, DTP_IDX_B_RH)) begin
      rd = st.rh[1];
    end else begin
      hit = 1'b0;
    end
    next_st.pready = acc;
    if (acc) begin
      next_st.prdata  = {{(DTP_DATA_W-8){1'b0}}, pwrite ? DTP_BYTE_ZERO : rd};
      next_st.pslverr = !hit;
    end
    if (wr) begin
      lo_wr[0] = dtp_hit(paddr, DTP_IDX_A_LO);
      lo_wr[1] = dtp_hit(paddr, DTP_IDX_B_LO);
      hi_wr[0] = dtp_hit(paddr, DTP_IDX_A_HI);
      hi_wr[1] = dtp_hit(paddr, DTP_IDX_B_HI);
      wr_lo[0] = pwdata[7:0];
      wr_lo[1] = pwdata[7:0];
      wr_hi[0] = pwdata[7:0];
      wr_hi[1] = pwdata[7:0];
      if (dtp_hit(paddr, DTP_IDX_CTRL)) begin
        next_st.ctrl = pwdata[7:0]; // R7
      end
      if (dtp_hit(paddr, DTP_IDX_MODE)) begin
        next_st.mode = pwdata[7:0];
      end
      if (dtp_hit(paddr, DTP_IDX_PWMPSC)) begin
        next_st.pwmpsc = pwdata[7:0];
      end
      if (dtp_hit(paddr, DTP_IDX_A_RL)) begin
        next_st.rl[0] = pwdata[7:0];
      end
      if (dtp_hit(paddr, DTP_IDX_B_RL)) begin
        next_st.rl[1] = pwdata[7:0];
      end
      if (dtp_hit(paddr, DTP_IDX_A_RH)) begin
        next_st.rh[0] = pwdata[7:0];
      end
      if (dtp_hit(paddr, DTP_IDX_B_RH)) begin
        next_st.rh[1] = pwdata[7:0];
      end
    end
    // Software write to a count byte overrides counting
    for (int i = 0; i < 2; i++) begin
      if (lo_wr[i]) begin
        next_st.lo[i] = wr_lo[i];
      end
      if (hi_wr[i]) begin
        next_st.hi[i] = wr_hi[i];
      end
    end

    // Overflow flags: hardware set wins over ack and software clear
    next_st.ctrl[DTP_A_OVF] = (next_st.ctrl[DTP_A_OVF] && !tmr_a_ack) || ovf[0]; // R6
    next_st.ctrl[DTP_B_OVF] = (next_st.ctrl[DTP_B_OVF] && !tmr_b_ack)
                              || (a_split ? split_hi_ovf : ovf[1]); // R6 R4 R5
    next_st.baud = ovf[1]; // R5

    // External interrupt flags
    if (st.ctrl[DTP_XA_TYPE]) begin
      next_st.ctrl[DTP_XA_FLAG] = (next_st.ctrl[DTP_XA_FLAG] && !ext_irq_a_ack) || pin_fall[2]; // R8 R10
    end else begin
      next_st.ctrl[DTP_XA_FLAG] = !pin_level[2]; // R9 R10
    end
    if (st.ctrl[DTP_XB_TYPE]) begin
      next_st.ctrl[DTP_XB_FLAG] = (next_st.ctrl[DTP_XB_FLAG] && !ext_irq_b_ack) || pin_fall[3]; // R8 R10
    end else begin
      next_st.ctrl[DTP_XB_FLAG] = !pin_level[3]; // R9 R10
    end

    // Pin drive enables, low while the PWM owns the pin
    next_st.oe_n[0] = !next_st.pwmpsc[DTP_A_PWM_EN]; // R15 R25
    next_st.oe_n[1] = !next_st.pwmpsc[DTP_B_PWM_EN]; // R15 R25
  end

  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      st        <= '0;
      st.ctrl   <= DTP_RST_CTRL;
      st.mode   <= DTP_RST_MODE;
      st.pwmpsc <= DTP_RST_PWMPSC; // R14
      st.rl     <= {DTP_RST_BYTE, DTP_RST_BYTE}; // R21
      st.rh     <= {DTP_RST_BYTE, DTP_RST_BYTE}; // R21
      st.oe_n   <= 2'h3;
    end else begin
      st <= next_st;
    end
  end

  // One PWM per timer, counting on the high byte
  for (genvar g = 0; g < 2; g++) begin : g_pwm
    dtp_pwm u_pwm (
      .sys_clk(sys_clk),
      .rst_n  (rst_sync_n),
      .pwm_en (st.pwmpsc[g == 0 ? DTP_A_PWM_EN : DTP_B_PWM_EN]), // R15
      .count  (st.hi[g]),
      .cmp_wr (st.rh[g]),
      .wrap   (hi_wrap[g]),
      .pwm_out(pwm_wave[g])
    );
  end

  assign pready              = st.pready;
  assign prdata              = st.prdata;
  assign pslverr             = st.pslverr;
  assign tmr_a_overflow_flag = st.ctrl[DTP_A_OVF];
  assign tmr_b_overflow_flag = st.ctrl[DTP_B_OVF];
  assign ext_irq_a_flag      = st.ctrl[DTP_XA_FLAG];
  assign ext_irq_b_flag      = st.ctrl[DTP_XB_FLAG];
  assign tmr_b_baud_tick     = st.baud;
  assign tmr_a_pin_out       = pwm_wave[0];
  assign tmr_b_pin_out       = pwm_wave[1];
  assign tmr_a_pin_oe_n      = st.oe_n[0];
  assign tmr_b_pin_oe_n      = st.oe_n[1];
endmodule : dtp_top

// ===== tb/dtp_props.sv
// Concurrent checks on the ports of the timer block
`timescale 1ns/1ps
module dtp_props
  import dtp_pkg::*;
(
  // Clock and reset
  input wire logic                          sys_clk,
  input wire logic                          rst_n,
  // APB
  input wire logic                          psel,
  input wire logic                          penable,
  input wire logic                          pwrite,
  input wire logic                          pready,
  input wire logic [dtp_pkg::DTP_DATA_W-1:0] prdata,
  input wire logic                          pslverr,
  // Flags and acknowledges
  input wire logic                          tmr_a_ack,
  input wire logic                          tmr_b_ack,
  input wire logic                          tmr_a_overflow_flag,
  input wire logic                          tmr_b_overflow_flag,
  // Pins
  input wire logic                          tmr_a_pin_out,
  input wire logic                          tmr_a_pin_oe_n,
  input wire logic                          tmr_b_pin_out,
  input wire logic                          tmr_b_pin_oe_n
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  logic wr_done;
  assign wr_done = psel && penable && pready && pwrite;
  sequence access_start;
    psel && penable && !$past(penable);
  endsequence
  sequence one_wait;
    !pready ##1 pready;
  endsequence
  chk_apb_wait: assert property (access_start |-> one_wait) else $error("pready not after one wait");
  chk_ready_pulse: assert property (pready |=> !pready) else $error("pready longer than one cycle");
  chk_ready_cause: assert property (pready |-> psel && penable) else $error("pready outside access");
  chk_data_upper: assert property (pready |-> prdata[31:8] == 24'h0) else $error("prdata upper bits set");
  chk_err_read: assert property (pready && pslverr |-> prdata == 32'h0) else $error("error read not zero");
  chk_a_pin_idle: assert property (tmr_a_pin_oe_n && $past(tmr_a_pin_oe_n) |-> !tmr_a_pin_out)
    else $error("timer A pin driven while idle");
  chk_b_pin_idle: assert property (tmr_b_pin_oe_n && $past(tmr_b_pin_oe_n) |-> !tmr_b_pin_out)
    else $error("timer B pin driven while idle");
  chk_a_flag_hold: assert property (tmr_a_overflow_flag && !tmr_a_ack && !wr_done |=> tmr_a_overflow_flag)
    else $error("timer A flag lost");
  chk_b_flag_hold: assert property (tmr_b_overflow_flag && !tmr_b_ack && !wr_done |=> tmr_b_overflow_flag)
    else $error("timer B flag lost");
endmodule : dtp_props
bind dtp_top dtp_props i_dtp_props (.sys_clk, .rst_n, .psel, .penable, .pwrite, .pready, .prdata, .pslverr,
  .tmr_a_ack, .tmr_b_ack, .tmr_a_overflow_flag, .tmr_b_overflow_flag, .tmr_a_pin_out, .tmr_a_pin_oe_n,
  .tmr_b_pin_out, .tmr_b_pin_oe_n);

// ===== tb/dtp_core_model.sv
// Processor core stand-in that vectors to pending interrupts
`timescale 1ns/1ps
module dtp_core_model (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  // Pending flags, enables, reaction speed
  input  wire logic [3:0] flags,
  input  wire logic [3:0] ack_en,
  input  wire logic       slow,
  // Vector acknowledges
  output logic            tmr_a_ack,
  output logic            tmr_b_ack,
  output logic            ext_irq_a_ack,
  output logic            ext_irq_b_ack
);
  logic [3:0] ack;
  logic [3:0] d1;
  logic [3:0] d2;
  logic [3:0] d3;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      {ack, d1, d2, d3} <= 16'h0;
    end else begin
      d1 <= flags;
      d2 <= d1;
      d3 <= d2;
      ack <= ack_en & flags & ~ack & (slow ? d3 : flags);
    end
  end
  assign {ext_irq_b_ack, ext_irq_a_ack, tmr_b_ack, tmr_a_ack} = ack;
endmodule : dtp_core_model

// ===== tb/dual_timer_counter_pwm_test.sv
// Self-checking bench for the timer block
`timescale 1ns/1ps
module dual_timer_counter_pwm_test;
  import dtp_pkg::*;
  logic                  sys_clk, rst_n, psel, penable, pwrite, pready, pslverr, slow, er;
  logic [DTP_ADDR_W-1:0] paddr;
  logic [DTP_DATA_W-1:0] pwdata, prdata;
  logic                  tmr_a_ack, tmr_b_ack, ext_irq_a_ack, ext_irq_b_ack, tmr_b_baud_tick;
  logic                  tmr_a_overflow_flag, tmr_b_overflow_flag, ext_irq_a_flag, ext_irq_b_flag;
  logic                  tmr_a_pin_out, tmr_a_pin_oe_n, tmr_b_pin_out, tmr_b_pin_oe_n;
  logic [1:0]            tpin, xpin, xf;
  logic [3:0]            ack_en;
  logic [7:0]            rv, d, h, rl, rh;
  logic [7:0]            ridx [5] = '{DTP_IDX_CTRL, DTP_IDX_MODE, DTP_IDX_PWMPSC, DTP_IDX_A_RL, DTP_IDX_B_RH};
  logic [7:0]            rexp [5] = '{8'h00, 8'h00, 8'h24, 8'h00, 8'h00};
  int                    err_total, checked, i, k, p, n;
  assign xf = {ext_irq_b_flag, ext_irq_a_flag};
  dtp_top i_dtp_top (.sys_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr,
    .tmr_a_ack, .tmr_b_ack, .ext_irq_a_ack, .ext_irq_b_ack, .tmr_a_overflow_flag, .tmr_b_overflow_flag,
    .ext_irq_a_flag, .ext_irq_b_flag, .tmr_b_baud_tick, .tmr_a_pin_in(tpin[0]), .tmr_b_pin_in(tpin[1]),
    .ext_irq_a_pin(xpin[0]), .ext_irq_b_pin(xpin[1]), .tmr_a_pin_out, .tmr_a_pin_oe_n, .tmr_b_pin_out,
    .tmr_b_pin_oe_n);
  dtp_core_model i_dtp_core_model (.sys_clk, .rst_n, .ack_en, .slow, .tmr_a_ack, .tmr_b_ack, .ext_irq_a_ack,
    .ext_irq_b_ack, .flags({ext_irq_b_flag, ext_irq_a_flag, tmr_b_overflow_flag, tmr_a_overflow_flag}));
  initial begin
    sys_clk = 0;
    forever #2 sys_clk = ~sys_clk;
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
    @(posedge sys_clk);
    psel <= 1;
    penable <= 0;
    pwrite <= wr;
    paddr <= {2'h0, idx, 2'h0};
    pwdata <= {24'h0, wd};
    @(posedge sys_clk);
    penable <= 1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rv = prdata[7:0];
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb
  task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
    apb(1, idx, wd);
  endtask : wr
  task automatic rd(input logic [7:0] idx);
    apb(0, idx, 8'h00);
  endtask : rd
  task automatic cyc(input int c);
    repeat (c) @(posedge sys_clk);
  endtask : cyc
  task automatic fall(input int t);
    @(posedge sys_clk);
    tpin[t] <= 0;
    cyc(3);
    tpin[t] <= 1;
    cyc(6);
  endtask : fall
  task automatic high_cnt(input int c);
    n = 0;
    repeat (c) begin
      @(posedge sys_clk);
      if (tmr_a_pin_out === 1'b1) n++;
    end
  endtask : high_cnt
  task automatic report_and_stop;
    $display("checks %0d errors %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : report_and_stop
  initial begin
    #(4 * 40000);
    err_total++;
    report_and_stop;
  end
  initial begin
    {psel, penable, pwrite, paddr, pwdata, slow, ack_en, rst_n} = '0;
    tpin = 2'b11;
    xpin = 2'b11;
    void'($urandom(24796));
    cyc(3);
    rst_n <= 1;
    cyc(3);
    for (i = 0; i < 5; i++) begin
      rd(ridx[i]);
      chk("reset value", rv, rexp[i]);
    end
    rd(8'h90);
    chk("unmapped err", er, 1);
    chk("unmapped data", rv, 0);
    d = $urandom;
    wr(DTP_IDX_B_RL, d);
    rd(DTP_IDX_B_RL);
    chk("reload rw", rv, d);
    h = $urandom;
    wr(DTP_IDX_MODE, 8'h0e);
    wr(DTP_IDX_A_HI, h);
    wr(DTP_IDX_A_LO, 8'hfd);
    xpin[0] <= 0;
    wr(DTP_IDX_CTRL, 8'h10);
    fall(0);
    rd(DTP_IDX_A_LO);
    chk("gated hold", rv, 8'hfd);
    xpin[0] <= 1;
    fall(0);
    fall(0);
    rd(DTP_IDX_A_LO);
    chk("count events", rv, 8'hff);
    chk("no early flag", tmr_a_overflow_flag, 0);
    fall(0);
    chk("mode2 flag", tmr_a_overflow_flag, 1);
    rd(DTP_IDX_A_LO);
    chk("mode2 reload", rv, h);
    rd(DTP_IDX_A_HI);
    chk("mode2 high kept", rv, h);
    ack_en <= 4'h1;
    cyc(6);
    chk("ack clears", tmr_a_overflow_flag, 0);
    {rl, rh} = $urandom;
    wr(DTP_IDX_MODE, 8'h05);
    wr(DTP_IDX_A_RL, rl);
    wr(DTP_IDX_A_RH, rh);
    wr(DTP_IDX_A_HI, 8'hff);
    wr(DTP_IDX_A_LO, 8'hfe);
    fall(0);
    fall(0);
    rd(DTP_IDX_A_LO);
    chk("ar16 low", rv, rl);
    rd(DTP_IDX_A_HI);
    chk("ar16 high", rv, rh);
    slow <= 1;
    cyc(10);
    chk("slow ack", tmr_a_overflow_flag, 0);
    p = $urandom % 3;
    wr(DTP_IDX_PWMPSC, 8'h20 | p[7:0]);
    wr(DTP_IDX_MODE, 8'h04);
    wr(DTP_IDX_A_HI, 8'hff);
    wr(DTP_IDX_A_LO, 8'h00);
    ack_en <= 4'h0;
    for (i = 1; i < (2 << p); i++) fall(0);
    chk("mode0 early", tmr_a_overflow_flag, 0);
    fall(0);
    chk("mode0 flag", tmr_a_overflow_flag, 1);
    rd(DTP_IDX_A_HI);
    chk("mode0 wrap", rv, 8'h00);
    d = $urandom;
    wr(DTP_IDX_B_LO, d);
    wr(DTP_IDX_MODE, 8'h37);
    wr(DTP_IDX_A_HI, 8'hf0);
    wr(DTP_IDX_A_LO, 8'hff);
    ack_en <= 4'h1;
    cyc(8);
    ack_en <= 4'h0;
    wr(DTP_IDX_CTRL, 8'h50);
    fall(0);
    chk("split low flag", tmr_a_overflow_flag, 1);
    cyc(12);
    chk("split high flag", tmr_b_overflow_flag, 1);
    rd(DTP_IDX_B_LO);
    chk("b held", rv, d);
    wr(DTP_IDX_MODE, 8'h27);
    k = 0;
    for (i = 0; i < 300 && k == 0; i++) begin
      @(posedge sys_clk);
      if (tmr_b_baud_tick === 1'b1) k = 1;
    end
    chk("baud tick", k, 1);
    wr(DTP_IDX_CTRL, 8'h00);
    ack_en <= 4'h3;
    cyc(10);
    chk("both acked", {tmr_b_overflow_flag, tmr_a_overflow_flag}, 0);
    for (k = 0; k < 2; k++) begin
      ack_en <= 4'h0;
      wr(DTP_IDX_CTRL, k ? 8'h04 : 8'h01);
      xpin[k] <= 0;
      cyc(8);
      chk("edge set", xf[k], 1);
      xpin[k] <= 1;
      cyc(8);
      chk("edge kept", xf[k], 1);
      ack_en[2 + k] <= 1;
      cyc(6);
      chk("edge acked", xf[k], 0);
      ack_en <= 4'h0;
      wr(DTP_IDX_CTRL, 8'h00);
      xpin[k] <= 0;
      cyc(8);
      chk("level low", xf[k], 1);
      xpin[k] <= 1;
      cyc(8);
      chk("level high", xf[k], 0);
    end
    wr(DTP_IDX_MODE, 8'h01);
    wr(DTP_IDX_A_RL, 8'hff);
    wr(DTP_IDX_A_RH, 8'h40);
    wr(DTP_IDX_PWMPSC, 8'h60);
    wr(DTP_IDX_CTRL, 8'h10);
    cyc(600);
    chk("pwm drives pin", tmr_a_pin_oe_n, 0);
    high_cnt(512);
    chk("duty 40", n, 128);
    @(posedge tmr_a_pin_out);
    wr(DTP_IDX_A_RH, 8'hc0);
    n = 0;
    while (tmr_a_pin_out === 1'b1 && n < 300) begin
      @(posedge sys_clk);
      n++;
    end
    chk("compare held back", n < 80, 1);
    cyc(300);
    high_cnt(512);
    chk("duty c0", n, 384);
    wr(DTP_IDX_A_RH, 8'h00);
    cyc(300);
    high_cnt(512);
    chk("zero compare low", n, 0);
    wr(DTP_IDX_PWMPSC, 8'h20);
    cyc(4);
    chk("pwm off oe", tmr_a_pin_oe_n, 1);
    chk("pwm off pin", tmr_a_pin_out, 0);
    report_and_stop;
  end
endmodule : dual_timer_counter_pwm_test
